//--- hw/plc_pkg.sv
// register map, field layout and carrier types of the loop configuration bank
//Contract
// - bit 7 of loop control: 0 keeps normal tuning sense, 1 inverts it; reset 0
// - bits 6:4 pick one of eight pump current steps; reset code 111
// - bits 3:2: 00 high impedance, 01 force source, 11 normal; reset 11
// - pump mode 10 forces continuous sinking regardless of the detector
// - reference divider is 14 bits; low byte register resets to one
// - reference divider upper six bits in bits 5:0 of next register, reset zero
// - six-bit residue counter in bits 5:0 of its register, reset zero
// - 13-bit modulus counter low byte register resets to three
// - modulus counter upper five bits in bits 4:0 of next register, reset zero
// - readback shows buffer copies unless the bank select bit is 1
// - while soft reset bit is 1 all loop registers and the readback select hold defaults; the bit itself stays writable and is not self-clearing
package plc_pkg;
	localparam int ADDR_W = 13;
	localparam int INSTR_BITS = 16;
	localparam int BYTE_BITS = 8;
	localparam int RW_BIT = 15;

	localparam logic [12:0] ADDR_PORT_CFG = 13'h000;
	localparam logic [12:0] ADDR_PART_ID = 13'h003;
	localparam logic [12:0] ADDR_READBACK = 13'h004;
	localparam logic [12:0] ADDR_LOOP_CTL = 13'h010;
	localparam logic [12:0] ADDR_RDIV_LO = 13'h011;
	localparam logic [12:0] ADDR_RDIV_HI = 13'h012;
	localparam logic [12:0] ADDR_RESIDUE = 13'h013;
	localparam logic [12:0] ADDR_MOD_LO = 13'h014;
	localparam logic [12:0] ADDR_MOD_HI = 13'h015;
	localparam logic [12:0] ADDR_UPDATE = 13'h232;

	localparam int SOFT_RST_BIT = 2;
	localparam int READBACK_SEL_BIT = 0;
	localparam int UPDATE_BIT = 0;
	localparam int PFD_POL_BIT = 7;
	localparam int PUMP_CUR_HI = 6;
	localparam int PUMP_CUR_LO = 4;
	localparam int PUMP_MODE_HI = 3;
	localparam int PUMP_MODE_LO = 2;
	localparam int PD_HI = 1;
	localparam int PD_LO = 0;

	localparam int RDIV_HI_W = 6;
	localparam int RESIDUE_W = 6;
	localparam int MOD_HI_W = 5;

	localparam logic [7:0] LOOP_CTL_RST = 8'h7d;
	localparam logic [7:0] RDIV_LO_RST = 8'h01;
	localparam logic [5:0] RDIV_HI_RST = 6'h00;
	localparam logic [5:0] RESIDUE_RST = 6'h00;
	localparam logic [7:0] MOD_LO_RST = 8'h03;
	localparam logic [4:0] MOD_HI_RST = 5'h00;

	localparam logic [1:0] PUMP_HIZ = 2'h0;
	localparam logic [1:0] PUMP_SOURCE = 2'h1;
	localparam logic [1:0] PUMP_SINK = 2'h2;
	localparam logic [1:0] PUMP_FOLLOW = 2'h3;
	localparam logic [1:0] PD_ASYNC = 2'h1;
	localparam logic [1:0] PD_SYNC = 2'h3;

	// fixed port configuration readback: long instruction bit and its mirror
	localparam logic [7:0] PORT_CFG_FIXED = 8'h18;
	localparam logic [7:0] PORT_CFG_SOFT = 8'h24;

	typedef struct packed {
		logic [7:0] loop_ctl;
		logic [7:0] rdiv_lo;
		logic [5:0] rdiv_hi;
		logic [5:0] residue;
		logic [7:0] mod_lo;
		logic [4:0] mod_hi;
	} plc_bank_s;

	localparam plc_bank_s BANK_RST = '{loop_ctl: LOOP_CTL_RST, rdiv_lo: RDIV_LO_RST, rdiv_hi: RDIV_HI_RST,
		residue: RESIDUE_RST, mod_lo: MOD_LO_RST, mod_hi: MOD_HI_RST};

	typedef struct packed {
		logic pfd_invert;
		logic [2:0] pump_current;
		logic pump_hiz;
		logic pump_source;
		logic pump_sink;
		logic pump_follow;
		logic pd_async;
		logic pd_sync;
		logic [13:0] ref_div;
		logic [5:0] residue;
		logic [12:0] modulus;
	} plc_loop_s;

	typedef struct packed {
		logic wr;
		logic [12:0] addr;
		logic [7:0] data;
	} plc_wr_s;

	typedef enum logic {PH_INSTR, PH_DATA} plc_phase_e;
endpackage : plc_pkg

//--- hw/plc_serial_port.sv
// serial control port slave: oversampled pins, instruction decode, byte streaming
module plc_serial_port
	import plc_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic csb_n,
	input wire logic sclk,
	input wire logic sdio_in,
	output logic sdio_out,
	output logic sdio_oe_n,
	output plc_wr_s wr,
	output logic [12:0] rd_addr,
	input wire logic [7:0] rd_data
);
	logic csb_m, csb_s, sclk_m, sclk_s, sclk_d, sdi_m, sdi_s;
	plc_phase_e phase, next_phase;
	logic [3:0] bit_cnt, next_bit_cnt;
	logic [15:0] shift, next_shift;
	logic [12:0] addr, next_addr;
	logic is_read, next_is_read;
	logic [7:0] out_sh, next_out_sh;
	logic next_sdio_out, next_sdio_oe_n;
	plc_wr_s next_wr;
	logic rise, fall;

	assign rise = sclk_s & ~sclk_d;
	assign fall = ~sclk_s & sclk_d;
	assign rd_addr = addr;

	always_comb begin
		next_phase = phase;
		next_bit_cnt = bit_cnt;
		next_shift = shift;
		next_addr = addr;
		next_is_read = is_read;
		next_out_sh = out_sh;
		next_sdio_out = sdio_out;
		next_sdio_oe_n = sdio_oe_n;
		next_wr = '{wr: 1'b0, addr: addr, data: shift[7:0]};
		if (csb_s) begin
			next_phase = PH_INSTR;
			next_bit_cnt = 4'h0;
			next_sdio_oe_n = 1'b1;
		end else if (rise) begin
			next_shift = {shift[14:0], sdi_s};
			if (phase == PH_INSTR) begin
				if (bit_cnt == 4'(INSTR_BITS - 1)) begin
					next_phase = PH_DATA;
					next_bit_cnt = 4'h0;
					next_is_read = next_shift[RW_BIT];
					next_addr = next_shift[12:0];
				end else begin
					next_bit_cnt = 4'(bit_cnt + 4'h1);
				end
			end else if (bit_cnt == 4'(BYTE_BITS - 1)) begin
				// msb-first streaming walks the address downward
				next_bit_cnt = 4'h0;
				next_addr = 13'(addr - 13'h1);
				next_wr.wr = ~is_read;
			end else begin
				next_bit_cnt = 4'(bit_cnt + 4'h1);
			end
		end else if (fall && phase == PH_DATA && is_read) begin
			next_sdio_oe_n = 1'b0;
			if (bit_cnt == 4'h0) begin
				next_sdio_out = rd_data[7];
				next_out_sh = {rd_data[6:0], 1'b0};
			end else begin
				next_sdio_out = out_sh[7];
				next_out_sh = {out_sh[6:0], 1'b0};
			end
		end
		if (next_wr.wr) begin
			next_wr.data = next_shift[7:0];
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			csb_m <= 1'b1;
			csb_s <= 1'b1;
			sclk_m <= 1'b0;
			sclk_s <= 1'b0;
			sclk_d <= 1'b0;
			sdi_m <= 1'b0;
			sdi_s <= 1'b0;
			phase <= PH_INSTR;
			bit_cnt <= 4'h0;
			shift <= 16'h0000;
			addr <= 13'h0000;
			is_read <= 1'b0;
			out_sh <= 8'h00;
			sdio_out <= 1'b0;
			sdio_oe_n <= 1'b1;
			wr <= '0;
		end else begin
			csb_m <= csb_n;
			csb_s <= csb_m;
			sclk_m <= sclk;
			sclk_s <= sclk_m;
			sclk_d <= sclk_s;
			sdi_m <= sdio_in;
			sdi_s <= sdi_m;
			phase <= next_phase;
			bit_cnt <= next_bit_cnt;
			shift <= next_shift;
			addr <= next_addr;
			is_read <= next_is_read;
			out_sh <= next_out_sh;
			sdio_out <= next_sdio_out;
			sdio_oe_n <= next_sdio_oe_n;
			wr <= next_wr;
		end
	end
endmodule : plc_serial_port

//--- hw/plc_loop_regs.sv
// loop configuration register bank with buffer and active copies
module plc_loop_regs
	import plc_pkg::*;
#(
	parameter logic [7:0] PART_ID = 8'h5a // arbitrary value
)
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic csb_n,
	input wire logic sclk,
	input wire logic sdio_in,
	output logic sdio_out,
	output logic sdio_oe_n,
	output plc_loop_s loop
);
	plc_wr_s wr;
	logic [12:0] rd_addr;
	logic [7:0] rd_data;
	plc_bank_s buf_q, next_buf;
	plc_bank_s act_q, next_act;
	plc_bank_s view;
	logic soft_rst, next_soft_rst;
	logic rb_sel, next_rb_sel;
	plc_loop_s next_loop;

	plc_serial_port u_port (
		.clk(clk),
		.nrst(nrst),
		.csb_n(csb_n),
		.sclk(sclk),
		.sdio_in(sdio_in),
		.sdio_out(sdio_out),
		.sdio_oe_n(sdio_oe_n),
		.wr(wr),
		.rd_addr(rd_addr),
		.rd_data(rd_data)
	);

	always_comb begin
		next_buf = buf_q;
		next_act = act_q;
		next_soft_rst = soft_rst;
		next_rb_sel = rb_sel;
		if (wr.wr) begin
			unique case (wr.addr)
				ADDR_PORT_CFG: next_soft_rst = wr.data[SOFT_RST_BIT];
				ADDR_READBACK: next_rb_sel = wr.data[READBACK_SEL_BIT];
				ADDR_LOOP_CTL: next_buf.loop_ctl = wr.data;
				ADDR_RDIV_LO: next_buf.rdiv_lo = wr.data;
				ADDR_RDIV_HI: next_buf.rdiv_hi = wr.data[RDIV_HI_W-1:0];
				ADDR_RESIDUE: next_buf.residue = wr.data[RESIDUE_W-1:0];
				ADDR_MOD_LO: next_buf.mod_lo = wr.data;
				ADDR_MOD_HI: next_buf.mod_hi = wr.data[MOD_HI_W-1:0];
				ADDR_UPDATE: begin
					// strobe bit is never stored, so it reads back as zero
					if (wr.data[UPDATE_BIT]) begin
						next_act = buf_q;
					end
				end
				default: begin
				end
			endcase
		end
		// soft reset pins the bank and clears the readback select; the bit itself stays writable so it can be released
		if (soft_rst) begin
			next_buf = BANK_RST;
			next_act = BANK_RST;
			next_rb_sel = 1'b0;
		end
	end

	always_comb begin
		view = rb_sel ? act_q : buf_q;
		rd_data = 8'h00;
		unique case (rd_addr)
			ADDR_PORT_CFG: rd_data = PORT_CFG_FIXED | (soft_rst ? PORT_CFG_SOFT : 8'h00);
			ADDR_PART_ID: rd_data = PART_ID;
			ADDR_READBACK: rd_data = {7'h00, rb_sel};
			ADDR_LOOP_CTL: rd_data = view.loop_ctl;
			ADDR_RDIV_LO: rd_data = view.rdiv_lo;
			ADDR_RDIV_HI: rd_data = {2'h0, view.rdiv_hi};
			ADDR_RESIDUE: rd_data = {2'h0, view.residue};
			ADDR_MOD_LO: rd_data = view.mod_lo;
			ADDR_MOD_HI: rd_data = {3'h0, view.mod_hi};
			default: rd_data = 8'h00;
		endcase
	end

	// one decode serves the reset image and the running outputs, so the two cannot drift apart
	function automatic plc_loop_s decode_loop(input plc_bank_s b);
		plc_loop_s l;
		l.pfd_invert = b.loop_ctl[PFD_POL_BIT];
		l.pump_current = b.loop_ctl[PUMP_CUR_HI:PUMP_CUR_LO];
		l.pump_hiz = b.loop_ctl[PUMP_MODE_HI:PUMP_MODE_LO] == PUMP_HIZ;
		l.pump_source = b.loop_ctl[PUMP_MODE_HI:PUMP_MODE_LO] == PUMP_SOURCE;
		l.pump_sink = b.loop_ctl[PUMP_MODE_HI:PUMP_MODE_LO] == PUMP_SINK;
		l.pump_follow = b.loop_ctl[PUMP_MODE_HI:PUMP_MODE_LO] == PUMP_FOLLOW;
		l.pd_async = b.loop_ctl[PD_HI:PD_LO] == PD_ASYNC;
		l.pd_sync = b.loop_ctl[PD_HI:PD_LO] == PD_SYNC;
		l.ref_div = {b.rdiv_hi, b.rdiv_lo};
		l.residue = b.residue;
		l.modulus = {b.mod_hi, b.mod_lo};
		return l;
	endfunction : decode_loop

	localparam plc_loop_s LOOP_RST = decode_loop(BANK_RST);

	// loop outputs decode only the active copy, never the buffer
	always_comb begin
		next_loop = decode_loop(act_q);
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			buf_q <= BANK_RST;
			act_q <= BANK_RST;
			soft_rst <= 1'b0;
			rb_sel <= 1'b0;
			loop <= LOOP_RST;
		end else begin
			buf_q <= next_buf;
			act_q <= next_act;
			soft_rst <= next_soft_rst;
			rb_sel <= next_rb_sel;
			loop <= next_loop;
		end
	end
endmodule : plc_loop_regs

//--- bench/plc_loop_regs_checker.sv
// concurrent checks on the loop configuration bank ports
module plc_loop_regs_checker
	import plc_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic csb_n,
	input wire logic sclk,
	input wire logic sdio_in,
	input wire logic sdio_out,
	input wire logic sdio_oe_n,
	input wire plc_loop_s loop
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);
	// port deselected long enough for the pin synchronisers to settle
	sequence s_idle;
		csb_n [*8];
	endsequence
	AST_RST_DIV: assert property ($rose(nrst) |-> loop.ref_div == 14'h1 && loop.modulus == 13'h3 && loop.residue == 6'h0)
		else $error("divider defaults wrong after reset");
	AST_RST_MODE: assert property ($rose(nrst) |-> loop.pump_follow && loop.pd_async && loop.pump_current == 3'h7 && !loop.pfd_invert)
		else $error("loop control defaults wrong after reset");
	AST_MODE_ONEHOT: assert property ($onehot({loop.pump_hiz, loop.pump_source, loop.pump_sink, loop.pump_follow}))
		else $error("pump mode flags not one-hot");
	AST_PD_EXCL: assert property (!(loop.pd_async && loop.pd_sync))
		else $error("both power-down flags set");
	AST_LOOP_QUIET: assert property (s_idle |=> $stable(loop))
		else $error("loop outputs moved while port idle");
	AST_LOOP_CAUSE: assert property (!$stable(loop) |-> !$past(csb_n, 16))
		else $error("loop outputs moved without a transfer");
	AST_OE_IDLE: assert property (s_idle |-> sdio_oe_n)
		else $error("data pin driven while deselected");
	AST_OE_READ: assert property ($fell(sdio_oe_n) |-> !csb_n && !sclk && !$past(csb_n, 8))
		else $error("data pin enabled outside a read");
endmodule : plc_loop_regs_checker

bind plc_loop_regs plc_loop_regs_checker chk_u (.clk(clk), .nrst(nrst), .csb_n(csb_n), .sclk(sclk),
	.sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe_n(sdio_oe_n), .loop(loop));

//--- bench/plc_host.sv
// serial host model driving the control port
module plc_host
(
	input wire logic clk,
	input wire logic sdio,
	output logic csb_n,
	output logic sclk,
	output logic sdo,
	output logic [7:0] rx,
	output logic rx_v
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		csb_n = 1'b1;
		sclk = 1'b0;
		sdo = 1'b0;
		rx = 8'h00;
		rx_v = 1'b0;
	end
	// released line shows the inverse of the last bit, never a held copy
	task automatic xfer(input logic rd, input logic [12:0] a, input logic [7:0] d);
		logic [23:0] w;
		w = {rd, 2'b00, a, d};
		@(negedge clk) csb_n <= 1'b0;
		repeat (4) @(negedge clk);
		for (int i = 23; i >= 0; i--) begin
			@(negedge clk) sclk <= 1'b0;
			sdo <= (rd && i < 8) ? ~sdo : w[i];
			repeat (6) @(negedge clk);
			sclk <= 1'b1;
			rx[i % 8] <= sdio;
			repeat (5) @(negedge clk);
		end
		@(negedge clk) sclk <= 1'b0;
		repeat (6) @(negedge clk);
		csb_n <= 1'b1;
		rx_v <= rd;
		@(negedge clk) rx_v <= 1'b0;
		repeat (8) @(negedge clk);
	endtask : xfer
endmodule : plc_host

//--- bench/plc_loop_regs_tb.sv
// self-checking bench for the loop configuration bank
module plc_loop_regs_tb
	import plc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] DFLT [6] = '{8'h7d, 8'h01, 8'h00, 8'h00, 8'h03, 8'h00};
	localparam logic [7:0] MASK [6] = '{8'hff, 8'hff, 8'h3f, 8'h3f, 8'hff, 8'h1f};
	localparam logic [7:0] TB_ID = 8'h3c; // arbitrary value
	logic clk, nrst, csb_n, sclk, sdo, sdio_out, sdio_oe_n, rx_v;
	logic [7:0] rx;
	wire sdio_w;
	plc_loop_s loop;
	int failures, n_checks, seed;
	logic [7:0] exp_q[$];
	logic [7:0] v [6];
	assign sdio_w = sdio_oe_n ? sdo : sdio_out;
	plc_loop_regs #(.PART_ID(TB_ID)) dut_u (.clk(clk), .nrst(nrst), .csb_n(csb_n), .sclk(sclk), .sdio_in(sdio_w),
		.sdio_out(sdio_out), .sdio_oe_n(sdio_oe_n), .loop(loop));
	plc_host h_u (.clk(clk), .sdio(sdio_w), .csb_n(csb_n), .sclk(sclk), .sdo(sdo), .rx(rx), .rx_v(rx_v));
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	always @(posedge clk) if (rx_v === 1'b1) chk(64'(rx), 64'(exp_q.pop_front()));
	task automatic wr(input logic [12:0] a, input logic [7:0] d);
		h_u.xfer(1'b0, a, d);
	endtask : wr
	task automatic rd(input logic [12:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		h_u.xfer(1'b1, a, 8'h00);
	endtask : rd
	task automatic end_of_test;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : end_of_test
	initial begin
		#400us;
		failures++;
		end_of_test();
	end
	// bench stands for an external oscillator, so inverted sense is legal
	initial begin
		seed = 9615;
		failures = 0;
		n_checks = 0;
		nrst = 1'b0;
		repeat (4) @(negedge clk);
		nrst = 1'b1;
		repeat (4) @(negedge clk);
		chk(64'({loop.pfd_invert, loop.pump_current, loop.pump_follow, loop.pd_async}), 64'h1f);
		for (int i = 0; i < 6; i++) rd(ADDR_LOOP_CTL + 13'(i), DFLT[i]);
		rd(ADDR_PART_ID, TB_ID);
		rd(ADDR_PORT_CFG, PORT_CFG_FIXED);
		for (int i = 0; i < 6; i++) begin
			v[i] = 8'($random(seed));
			wr(ADDR_LOOP_CTL + 13'(i), v[i]);
		end
		for (int i = 0; i < 6; i++) rd(ADDR_LOOP_CTL + 13'(i), v[i] & MASK[i]);
		chk(64'(loop.ref_div), 64'h1);
		wr(ADDR_READBACK, 8'h01);
		rd(ADDR_READBACK, 8'h01);
		rd(ADDR_RDIV_LO, 8'h01);
		wr(ADDR_UPDATE, 8'h01);
		rd(ADDR_RDIV_LO, v[1]);
		wr(ADDR_READBACK, 8'h00);
		chk(64'({loop.ref_div, loop.residue, loop.modulus}), 64'({v[2][5:0], v[1], v[3][5:0], v[5][4:0], v[4]}));
		for (int m = 0; m < 8; m++) begin
			wr(ADDR_LOOP_CTL, {m[0], m[2:0], m[1:0], m[1:0]});
			wr(ADDR_UPDATE, 8'h01);
			chk(64'({loop.pfd_invert, loop.pump_current, loop.pump_follow, loop.pump_sink, loop.pump_source,
				loop.pump_hiz, loop.pd_sync, loop.pd_async}),
				64'({m[0], m[2:0], 4'h1 << m[1:0], m[1:0] == 2'h3, m[1:0] == 2'h1}));
		end
		wr(ADDR_PORT_CFG, 8'h24);
		rd(ADDR_LOOP_CTL, 8'h7d);
		rd(ADDR_PORT_CFG, PORT_CFG_FIXED | PORT_CFG_SOFT);
		wr(ADDR_RDIV_LO, 8'h77);
		rd(ADDR_RDIV_LO, 8'h01);
		chk(64'({loop.ref_div, loop.modulus, loop.pump_follow}), 64'({14'h1, 13'h3, 1'b1}));
		wr(ADDR_PORT_CFG, 8'h00);
		wr(ADDR_MOD_LO, 8'h5c);
		rd(ADDR_MOD_LO, 8'h5c);
		wr(13'h020, 8'ha5);
		rd(13'h020, 8'h00);
		wr(ADDR_UPDATE, 8'h01);
		chk(64'(loop.modulus), 64'h05c);
		// second reset in mid-run must bring both copies and the outputs back
		@(negedge clk);
		nrst = 1'b0;
		repeat (4) @(negedge clk);
		nrst = 1'b1;
		repeat (4) @(negedge clk);
		chk(64'({loop.ref_div, loop.modulus, loop.pump_follow}), 64'({14'h1, 13'h3, 1'b1}));
		rd(ADDR_MOD_LO, 8'h03);
		repeat (4) @(negedge clk);
		chk(64'(exp_q.size()), 64'h0);
		end_of_test();
	end
endmodule : plc_loop_regs_tb
